// *** verilog/tdl_trim_cfg.v ***
`default_nettype none
`include "tdl_regs.vh"
module tdl_trim_cfg (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // avalon-mm slave
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // sample stream
  input  wire [11:0] sampleIn,
  input  wire        sampleValid,
  input  wire        stampPin,
  output reg  [11:0] sampleOut,
  output reg         sampleOutValid,
  // trim and control outputs
  output wire [7:0]  gainTrimA,
  output wire [7:0]  gainTrimB,
  output wire [3:0]  bgapTrim,
  output wire [7:0]  termTrimA,
  output wire [7:0]  termTrimB,
  output wire        ditherOn,
  output wire        ditherAmpLarge,
  output wire        ditherRoundOffset,
  output wire        syncPinReceiverOn,
  output wire        calOn,
  output wire        serialReset,
  output wire        serializerPowerDown,
  output wire        serialClkGate,
  output wire        frameCntReset,
  output wire        sysrefAccept,
  output wire [4:0]  ilaCtrlBits
);
  localparam ST_LOAD = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RUN  = 2'd2;

  reg  [1:0]  state_q;
  reg  [2:0]  fuseIdx_q;
  reg         fuseValid_q;
  wire [7:0]  fuseData;
  reg  [7:0]  gainA_q;
  reg  [7:0]  gainB_q;
  reg  [7:0]  bgap_q;
  reg  [7:0]  termA_q;
  reg  [7:0]  termB_q;
  reg  [7:0]  dither_q;
  reg  [7:0]  lsbCtl_q;
  reg  [7:0]  serOut_q;
  reg  [7:0]  calCtl_q;
  reg         ack_q;
  reg         stampSync1_q, stampSync2_q;
  reg  [`TDL_PIPE_STAGES-1:0] stampPipe_q;
  reg  [12*`TDL_PIPE_STAGES-1:0] dataPipe_q;
  reg  [`TDL_PIPE_STAGES-1:0] validPipe_q;
  wire [9:0]  idx;
  wire        busy;
  wire        wrEn;
  wire [11:0] lastData;
  wire        lastStamp;

  assign idx  = avs_address[11:2];
  assign busy = (state_q != ST_RUN);
  // reads and writes wait until the factory load is complete; one wait cycle otherwise
  assign avs_waitrequest = (avs_read | avs_write) & (busy | ~ack_q);
  assign wrEn = avs_write & ~busy & ack_q & avs_byteenable[0];

  tdl_fuse_rom u_fuse (
    .sys_clk (sys_clk),
    .addr    (fuseIdx_q),
    .rdData  (fuseData)
  );

  // fuse fetch sequencer: one word per cycle after release of reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_LOAD;
      fuseIdx_q   <= 3'h0;
      fuseValid_q <= 1'b0;
    end else begin
      case (state_q)
        ST_LOAD: begin
          fuseValid_q <= 1'b1;
          if (fuseIdx_q == 3'd`TDL_FUSE_WORDS - 3'd1) begin
            state_q <= ST_WAIT;
          end else begin
            fuseIdx_q <= fuseIdx_q + 3'd1;
          end
        end
        ST_WAIT: begin
          fuseValid_q <= 1'b0;
          state_q     <= ST_RUN;
        end
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  // rom data lags its address by one cycle
  reg [2:0] fuseIdxD_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuseIdxD_q <= 3'h0;
    end else begin
      fuseIdxD_q <= fuseIdx_q;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~busy & ~ack_q;
    end
  end

  // factory load strobes: a word lands the cycle after the rom returns it
  wire        fuseLdGainA;
  wire        fuseLdGainB;
  wire        fuseLdBgap;
  wire        fuseLdTermA;
  wire        fuseLdTermB;
  // software write strobes, one per register
  wire        wrGainA;
  wire        wrGainB;
  wire        wrBgap;
  wire        wrTermA;
  wire        wrTermB;
  wire        wrDither;
  wire        wrLsbCtl;
  wire        wrSerOut;
  wire        wrCalCtl;

  assign fuseLdGainA = fuseValid_q & (fuseIdxD_q == 3'h0);
  assign fuseLdGainB = fuseValid_q & (fuseIdxD_q == 3'h1);
  assign fuseLdBgap  = fuseValid_q & (fuseIdxD_q == 3'h2);
  assign fuseLdTermA = fuseValid_q & (fuseIdxD_q == 3'h3);
  assign fuseLdTermB = fuseValid_q & (fuseIdxD_q == 3'h4);
  assign wrGainA     = wrEn & (idx == `TDL_IDX_GAIN_A);
  assign wrGainB     = wrEn & (idx == `TDL_IDX_GAIN_B);
  assign wrBgap      = wrEn & (idx == `TDL_IDX_BGAP);
  assign wrTermA     = wrEn & (idx == `TDL_IDX_TERM_A);
  assign wrTermB     = wrEn & (idx == `TDL_IDX_TERM_B);
  assign wrDither    = wrEn & (idx == `TDL_IDX_DITHER);
  assign wrLsbCtl    = wrEn & (idx == `TDL_IDX_LSBCTL);
  assign wrSerOut    = wrEn & (idx == `TDL_IDX_SEROUT);
  assign wrCalCtl    = wrEn & (idx == `TDL_IDX_CALCTL);

  // trim words: zero in reset, then the factory word, then software
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gainA_q <= `TDL_RST_TRIM;
    end else if (fuseLdGainA) begin
      gainA_q <= fuseData;
    end else if (wrGainA) begin
      gainA_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gainB_q <= `TDL_RST_TRIM;
    end else if (fuseLdGainB) begin
      gainB_q <= fuseData;
    end else if (wrGainB) begin
      gainB_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bgap_q <= `TDL_RST_TRIM;
    end else if (fuseLdBgap) begin
      bgap_q <= {4'h0, fuseData[`TDL_BGAP_MSB:0]};
    end else if (wrBgap) begin
      bgap_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      termA_q <= `TDL_RST_TRIM;
    end else if (fuseLdTermA) begin
      termA_q <= fuseData;
    end else if (wrTermA) begin
      termA_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      termB_q <= `TDL_RST_TRIM;
    end else if (fuseLdTermB) begin
      termB_q <= fuseData;
    end else if (wrTermB) begin
      termB_q <= avs_writedata[7:0];
    end
  end

  // control words hold reserved bits as plain storage
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dither_q <= `TDL_RST_DITHER;
    end else if (wrDither) begin
      dither_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lsbCtl_q <= `TDL_RST_LSBCTL;
    end else if (wrLsbCtl) begin
      lsbCtl_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serOut_q <= `TDL_RST_SEROUT;
    end else if (wrSerOut) begin
      serOut_q <= avs_writedata[7:0];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      calCtl_q <= `TDL_RST_CALCTL;
    end else if (wrCalCtl) begin
      calCtl_q <= avs_writedata[7:0];
    end
  end

  // the read word is captured in the first cycle of a request after the factory load and then frozen
  wire        rdTake;
  assign rdTake = avs_read & ~busy & ~ack_q;

  // read mux; unmapped addresses answer zero
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rdTake) begin
      case (idx)
        `TDL_IDX_GAIN_A: avs_readdata <= {24'h0, gainA_q};
        `TDL_IDX_GAIN_B: avs_readdata <= {24'h0, gainB_q};
        `TDL_IDX_BGAP:   avs_readdata <= {24'h0, bgap_q};
        `TDL_IDX_TERM_A: avs_readdata <= {24'h0, termA_q};
        `TDL_IDX_TERM_B: avs_readdata <= {24'h0, termB_q};
        `TDL_IDX_DITHER: avs_readdata <= {24'h0, dither_q};
        `TDL_IDX_LSBCTL: avs_readdata <= {24'h0, lsbCtl_q};
        `TDL_IDX_SEROUT: avs_readdata <= {24'h0, serOut_q};
        `TDL_IDX_CALCTL: avs_readdata <= {24'h0, calCtl_q};
        `TDL_IDX_STATUS: avs_readdata <= {30'h0, serialReset, busy};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign gainTrimA         = gainA_q;
  assign gainTrimB         = gainB_q;
  assign bgapTrim          = bgap_q[`TDL_BGAP_MSB:0];
  assign termTrimA         = termA_q;
  assign termTrimB         = termB_q;
  assign ditherOn          = dither_q[`TDL_BIT_DITHER_ON];
  assign ditherAmpLarge    = dither_q[`TDL_BIT_DITHER_AMP];
  assign ditherRoundOffset = dither_q[`TDL_BIT_DITHER_RND];
  // receiver enable is software's job; it sits beside cal enable here
  assign syncPinReceiverOn = calCtl_q[`TDL_BIT_SYNC_RX_ON];
  assign calOn             = calCtl_q[`TDL_BIT_CAL_ON];
  // ordering against cal enable is software's duty and is not interlocked
  assign serialReset         = ~serOut_q[`TDL_BIT_SEROUT_ON];
  assign serializerPowerDown = ~serOut_q[`TDL_BIT_SEROUT_ON];
  assign serialClkGate       = ~serOut_q[`TDL_BIT_SEROUT_ON];
  assign frameCntReset       = ~serOut_q[`TDL_BIT_SEROUT_ON];
  assign sysrefAccept        = serOut_q[`TDL_BIT_SEROUT_ON];
  assign ilaCtrlBits         = 5'h00;

  // timestamp pin: two-flop sync, then the same pipeline depth as the data
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stampSync1_q <= 1'b0;
      stampSync2_q <= 1'b0;
    end else begin
      stampSync1_q <= stampPin;
      stampSync2_q <= stampSync1_q;
    end
  end

  // next stage values; stage zero takes the synchronised pin and the raw sample
  wire [`TDL_PIPE_STAGES-1:0]    stampPipe_d;
  wire [12*`TDL_PIPE_STAGES-1:0] dataPipe_d;
  wire [`TDL_PIPE_STAGES-1:0]    validPipe_d;

  genvar g;
  generate
    for (g = 0; g < `TDL_PIPE_STAGES; g = g + 1) begin : gPipe
      if (g == 0) begin : gHead
        assign stampPipe_d[g]         = stampSync2_q;
        assign dataPipe_d[12*g +: 12] = sampleIn;
        assign validPipe_d[g]         = sampleValid;
      end else begin : gBody
        assign stampPipe_d[g]         = stampPipe_q[g-1];
        assign dataPipe_d[12*g +: 12] = dataPipe_q[12*(g-1) +: 12];
        assign validPipe_d[g]         = validPipe_q[g-1];
      end
    end
  endgenerate

  // one process moves all stages so each pipeline register has a single driver
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stampPipe_q <= {`TDL_PIPE_STAGES{1'b0}};
      dataPipe_q  <= {(12*`TDL_PIPE_STAGES){1'b0}};
      validPipe_q <= {`TDL_PIPE_STAGES{1'b0}};
    end else begin
      stampPipe_q <= stampPipe_d;
      dataPipe_q  <= dataPipe_d;
      validPipe_q <= validPipe_d;
    end
  end

  assign lastData  = dataPipe_q[12*`TDL_PIPE_STAGES-1 -: 12];
  assign lastStamp = stampPipe_q[`TDL_PIPE_STAGES-1];

  // 8-bit samples sit in [11:4]; the stamp replaces that mode's own lsb
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleOut      <= 12'h000;
      sampleOutValid <= 1'b0;
    end else begin
      sampleOutValid <= validPipe_q[`TDL_PIPE_STAGES-1] & ~serialReset;
      if (!lsbCtl_q[`TDL_BIT_STAMP_ON]) begin
        sampleOut <= lastData;
      end else if (lsbCtl_q[4 + `TDL_BIT_MODE12]) begin
        sampleOut <= {lastData[11:1], lastStamp};
      end else begin
        sampleOut <= {lastData[11:5], lastStamp, 4'h0};
      end
    end
  end
endmodule // tdl_trim_cfg
`default_nettype wire

// *** include/tdl_regs.vh ***
`ifndef TDL_REGS_VH
`define TDL_REGS_VH
// register word indices (printed offsets are not all multiples of four: byte address = index * 4)
`define TDL_IDX_GAIN_A      10'h07a
`define TDL_IDX_GAIN_B      10'h07b
`define TDL_IDX_BGAP        10'h07c
`define TDL_IDX_TERM_A      10'h07e
`define TDL_IDX_TERM_B      10'h07f
`define TDL_IDX_DITHER      10'h09d
`define TDL_IDX_LSBCTL      10'h160
`define TDL_IDX_SEROUT      10'h200
`define TDL_IDX_CALCTL      10'h3f0
`define TDL_IDX_STATUS      10'h3f1
`define TDL_RST_DITHER      8'h01
`define TDL_RST_LSBCTL      8'h00
`define TDL_RST_SEROUT      8'h01
`define TDL_RST_CALCTL      8'h00
`define TDL_RST_TRIM        8'h00
`define TDL_BIT_DITHER_ON   0
`define TDL_BIT_DITHER_AMP  1
`define TDL_BIT_DITHER_RND  2
`define TDL_BIT_STAMP_ON    0
`define TDL_BIT_SEROUT_ON   0
`define TDL_BIT_CAL_ON      0
`define TDL_BIT_SYNC_RX_ON  1
`define TDL_BIT_MODE12      0
`define TDL_BGAP_MSB        3
// factory words, fetched one per cycle from fuse storage
`define TDL_FUSE_WORDS      5
`define TDL_PIPE_STAGES     4
`define TDL_CLK_MHZ         10
`endif

// *** verilog/tdl_fuse_rom.v ***
`default_nettype none
`include "tdl_regs.vh"
module tdl_fuse_rom (
  // clock
  input  wire       sys_clk,
  // read port
  input  wire [2:0] addr,
  output reg  [7:0] rdData
);
  parameter [7:0] FUSE_GAIN_A = 8'h80;
  parameter [7:0] FUSE_GAIN_B = 8'h80;
  parameter [7:0] FUSE_BGAP   = 8'h08;
  parameter [7:0] FUSE_TERM_A = 8'h40;
  parameter [7:0] FUSE_TERM_B = 8'h40;

  // registered output models the fuse sense amplifier latch
  always @(posedge sys_clk) begin
    case (addr)
      3'h0:    rdData <= FUSE_GAIN_A;
      3'h1:    rdData <= FUSE_GAIN_B;
      3'h2:    rdData <= FUSE_BGAP;
      3'h3:    rdData <= FUSE_TERM_A;
      3'h4:    rdData <= FUSE_TERM_B;
      default: rdData <= 8'h00;
    endcase
  end
endmodule // tdl_fuse_rom
`default_nettype wire

// *** test/tdl_trim_cfg_asserts.sv ***
`default_nettype none
module tdl_trim_cfg_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // register bus
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // controls
  input wire logic        sampleOutValid,
  input wire logic [7:0]  gainTrimA,
  input wire logic        ditherOn,
  input wire logic        ditherAmpLarge,
  input wire logic        ditherRoundOffset,
  input wire logic        serialReset,
  input wire logic        serializerPowerDown,
  input wire logic        serialClkGate,
  input wire logic        frameCntReset,
  input wire logic        sysrefAccept,
  input wire logic [4:0]  ilaCtrlBits
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  property p_bus; (avs_read || avs_write) |-> ##[0:12] !avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus request not answered");
  property p_gain; acc && avs_address == 12'h1e8 |=> gainTrimA == $past(avs_writedata[7:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain trim write lost");
  property p_dith; acc && avs_address == 12'h274 |=>
    ditherOn == $past(avs_writedata[0]) && ditherAmpLarge == $past(avs_writedata[1]); endproperty
  a_dith: assert property (p_dith) else $error("dither bits wrong");
  property p_rnd; acc && avs_address == 12'h274 |=> ditherRoundOffset == $past(avs_writedata[2]);
  endproperty
  a_rnd: assert property (p_rnd) else $error("rounding select wrong");
  property p_en; acc && avs_address == 12'h800 |=> sysrefAccept == $past(avs_writedata[0]);
  endproperty
  a_en: assert property (p_en) else $error("serial enable wrong");
  property p_off; serialReset |-> serializerPowerDown && serialClkGate && frameCntReset; endproperty
  a_off: assert property (p_off) else $error("serial block not held off");
  property p_sync; sysrefAccept != serialReset; endproperty
  a_sync: assert property (p_sync) else $error("alignment accepted while off");
  property p_gate; serialReset && $past(serialReset) |-> !sampleOutValid; endproperty
  a_gate: assert property (p_gate) else $error("samples leave while off");
  property p_ila; ilaCtrlBits == 5'h00; endproperty
  a_ila: assert property (p_ila) else $error("control bits advertised");
  property p_rdz; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data upper bits set");
endmodule // tdl_trim_cfg_asserts
bind tdl_trim_cfg tdl_trim_cfg_asserts u_chk (.*);
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
`include "tdl_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset_n, avs_read, avs_write, sampleValid, stampPin;
  logic [11:0] avs_address, sampleIn;
  logic [31:0] avs_writedata, rdv;
  logic [3:0]  avs_byteenable;
  wire  [31:0] avs_readdata;
  wire  [11:0] sampleOut;
  wire  [7:0]  gainTrimA, gainTrimB, termTrimA, termTrimB;
  wire  [3:0]  bgapTrim;
  wire  [4:0]  ilaCtrlBits;
  wire         avs_waitrequest, sampleOutValid, serialReset, serializerPowerDown, serialClkGate;
  wire         frameCntReset, sysrefAccept, ditherOn, ditherAmpLarge, ditherRoundOffset;
  wire         syncPinReceiverOn, calOn;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [9:0]  ra [8] = '{`TDL_IDX_GAIN_A, `TDL_IDX_GAIN_B, `TDL_IDX_BGAP, `TDL_IDX_TERM_A,
                          `TDL_IDX_TERM_B, `TDL_IDX_DITHER, `TDL_IDX_LSBCTL, `TDL_IDX_SEROUT};
  // factory words are the fuse model defaults
  logic [7:0]  rv [8] = '{8'h80, 8'h80, 8'h08, 8'h40, 8'h40, `TDL_RST_DITHER, `TDL_RST_LSBCTL,
                          `TDL_RST_SEROUT};
  logic [11:0] sx [4] = '{12'ha40, 12'ha4c, 12'ha50, 12'ha4d};
  tdl_trim_cfg u_dut (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (avs_waitrequest) begin
      error_cnt++;
      $display("[FAIL] %0t bus timeout", $time);
      end_of_test;
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rc(input logic [9:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rdv, {24'h0, e});
  endtask
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    sampleIn = 12'ha4c;
    sampleValid = 1'b1;
    stampPin = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
    bus(1'b1, `TDL_IDX_CALCTL, 8'h03);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ra[i], 8'h5a ^ i[7:0]);
      rc(ra[i], 8'h5a ^ i[7:0]);
    end
    @(negedge sys_clk);
    chk({gainTrimA, gainTrimB, termTrimA, termTrimB}, 32'h5a5b595e);
    chk({bgapTrim, syncPinReceiverOn, calOn}, 6'h23);
    bus(1'b1, 10'h004, 8'hff);
    rc(10'h004, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `TDL_IDX_DITHER, i[7:0]);
      @(negedge sys_clk);
      chk({ditherRoundOffset, ditherAmpLarge, ditherOn}, i);
    end
    bus(1'b1, `TDL_IDX_SEROUT, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk({serialReset, serializerPowerDown, serialClkGate, frameCntReset, sysrefAccept,
         sampleOutValid}, 6'b111100);
    bus(1'b1, `TDL_IDX_SEROUT, 8'h01);
    repeat (8) @(negedge sys_clk);
    chk({serialReset, serialClkGate, sysrefAccept, sampleOutValid}, 4'b0011);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `TDL_IDX_LSBCTL, m[0] ? 8'h11 : 8'h01);
      stampPin <= m[1];
      repeat (10) @(negedge sys_clk);
      chk(sampleOut, sx[m]);
    end
    // stamp leads its sample by the two synchroniser stages
    stampPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    stampPin <= 1'b1;
    @(posedge sys_clk);
    stampPin <= 1'b0;
    @(posedge sys_clk);
    sampleIn <= 12'h120;
    @(posedge sys_clk);
    sampleIn <= 12'ha4c;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(sampleOut, 12'h121);
    @(negedge sys_clk);
    chk(sampleOut, 12'ha4c);
    bus(1'b1, `TDL_IDX_SEROUT, 8'h00);
    bus(1'b1, `TDL_IDX_CALCTL, 8'h00);
    rc(`TDL_IDX_SEROUT, 8'h00);
    rc(`TDL_IDX_CALCTL, 8'h00);
    // a second reset in mid-run must bring the factory words back
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
